// ---- flash_space_mapping.sv ----
// code-read mapping, column-latch buffer and boot selection for the on-chip flash
`timescale 1ns/1ps
module flash_space_mapping (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // code read port from the core
  input wire logic code_rd_i,
  input wire logic [15:0] code_addr_i,
  output logic [7:0] code_data_o,
  output logic code_valid_o,
  // data write port from the core
  input wire logic data_wr_i,
  input wire logic [15:0] data_addr_i,
  input wire logic [7:0] data_wdata_i,
  input wire logic external_data_map_i,
  output logic xdata_wr_o,
  output logic [15:0] xdata_addr_o,
  output logic [7:0] xdata_wdata_o,
  output logic xdata_external_o,
  // flash control register access
  input wire logic flash_control_wr_i,
  input wire logic [7:0] flash_control_wdata_i,
  output logic [7:0] flash_control_reg_o,
  input wire logic flash_busy_i,
  // aux config one: boot array enable
  input wire logic aux_config_one_wr_i,
  input wire logic boot_flash_enable_i,
  output logic boot_flash_enable_o,
  // security byte
  input wire logic sec_sw_wr_i,
  input wire logic [7:0] sec_sw_wdata_i,
  input wire logic sec_hw_wr_i,
  input wire logic [3:0] sec_hw_low_i,
  output logic [7:0] security_byte_o,
  // boot flags, written through the loader api
  input wire logic boot_cfg_wr_i,
  input wire logic loader_jump_select_i,
  input wire logic [7:0] user_loader_vector_i,
  output logic loader_jump_select_o,
  output logic [7:0] user_loader_vector_o,
  output logic [15:0] start_addr_o,
  // column latch view for the programming engine
  input wire logic [6:0] latch_rd_idx_i,
  output logic [7:0] latch_rd_data_o,
  output logic [7:0] latch_page_o,
  output logic latch_wr_o,
  // commit port for the programming engine
  input wire logic prog_wr_i,
  input wire flash_map_pkg::space_type prog_space_i,
  input wire logic [15:0] prog_addr_i,
  input wire logic [7:0] prog_data_i
);

  typedef struct packed {
    logic [7:0] ctrl;
    logic busy;
    logic boot_en;
    logic boot_init;
    logic ljs;
    logic [7:0] ulv;
    logic [7:0] sec;
    logic rd_pend;
    logic rd_is_sec;
    logic [7:0] code_data;
    logic code_valid;
    logic xwr;
    logic [15:0] xaddr;
    logic [7:0] xdata;
    logic xext;
    logic cl_wr;
    logic [7:0] cl_page;
    logic [15:0] start_addr;
  } state_type;

  state_type state_q;
  state_type state_d;

  logic [7:0] col_latch [flash_map_pkg::PAGE_BYTES];
  logic [7:0] latch_rd_q;
  logic latch_hit;
  flash_map_pkg::space_type rd_space;

  flash_array_if arr ();

  flash_arrays #(
    .PAGE_BYTES(flash_map_pkg::PAGE_BYTES),
    .USER_PAGES(flash_map_pkg::USER_PAGES),
    .BOOT_BYTES(flash_map_pkg::BOOT_BYTES)
  ) u_arrays (
    .clock_i(clock_i),
    .arr(arr.store)
  );

  // decode of a code read address to the space that answers it
  function automatic flash_map_pkg::space_type map_space(
    input logic [7:0] ctrl,
    input logic boot_en,
    input logic [15:0] addr
  );
    logic [1:0] map_sel;
    map_sel = ctrl[flash_map_pkg::CTRL_MAP_LSB +: 2];
    if (map_sel == flash_map_pkg::MAP_SEC && addr == flash_map_pkg::SEC_ADDR) begin
      map_space = flash_map_pkg::SPACE_SEC;
    end else if (map_sel == flash_map_pkg::MAP_ROW && addr >= flash_map_pkg::ROW_BASE) begin
      map_space = flash_map_pkg::SPACE_ROW;
    end else if (boot_en && addr >= flash_map_pkg::BOOT_BASE) begin
      map_space = flash_map_pkg::SPACE_BOOT;
    end else begin
      map_space = flash_map_pkg::SPACE_USER;
    end
  endfunction : map_space

  // a data write that belongs in the column latches
  function automatic logic in_latch_range(
    input logic [7:0] ctrl,
    input logic [15:0] addr
  );
    in_latch_range = ctrl[flash_map_pkg::CTRL_PBUF_BIT]
                     && (addr <= flash_map_pkg::COL_LATCH_TOP);
  endfunction : in_latch_range

  assign rd_space = map_space(state_q.ctrl, state_q.boot_en, code_addr_i);
  assign latch_hit = data_wr_i && in_latch_range(state_q.ctrl, data_addr_i);

  // the user array is only ever read here; its write path is the programming commit
  assign arr.rd_en = code_rd_i;
  assign arr.rd_space = rd_space;
  assign arr.rd_addr = code_addr_i;
  assign arr.wr_en = prog_wr_i;
  assign arr.wr_space = prog_space_i;
  assign arr.wr_addr = prog_addr_i;
  assign arr.wr_data = prog_data_i;

  always_comb begin
    state_d = state_q;

    // busy is read-only to software and mirrors the programming engine
    state_d.busy = flash_busy_i;
    if (flash_control_wr_i) begin
      state_d.ctrl = flash_control_wdata_i & 8'hFE;
    end

    if (aux_config_one_wr_i) begin
      state_d.boot_en = boot_flash_enable_i;
    end

    // boot flags: start address and boot array map settle on the first edge after reset
    if (boot_cfg_wr_i) begin
      state_d.ljs = loader_jump_select_i;
      state_d.ulv = user_loader_vector_i;
    end
    if (!state_q.boot_init) begin
      state_d.boot_init = 1'b1;
      state_d.boot_en = ~state_q.ljs;
    end
    state_d.start_addr = state_q.ljs ? flash_map_pkg::USER_START
                                     : flash_map_pkg::BOOT_BASE;

    // a hardware nibble write and a software write in one cycle each keep their half
    if (sec_sw_wr_i) begin
      state_d.sec = (sec_sw_wdata_i & flash_map_pkg::SEC_SW_MASK)
                  | (state_q.sec & ~flash_map_pkg::SEC_SW_MASK);
    end
    if (sec_hw_wr_i) begin
      state_d.sec[3:0] = sec_hw_low_i;
    end

    // code read: array answers one edge later, the output register the next
    state_d.rd_pend = code_rd_i;
    state_d.rd_is_sec = code_rd_i && (rd_space == flash_map_pkg::SPACE_SEC);
    state_d.code_valid = state_q.rd_pend;
    if (state_q.rd_pend) begin
      state_d.code_data = state_q.rd_is_sec ? state_q.sec : arr.rd_data;
    end

    // data write routing: latch range steals the write from the data memory
    state_d.cl_wr = latch_hit;
    state_d.xwr = data_wr_i && !latch_hit;
    if (data_wr_i && !latch_hit) begin
      state_d.xaddr = data_addr_i;
      state_d.xdata = data_wdata_i;
      state_d.xext = external_data_map_i;
    end
    if (latch_hit) begin
      state_d.cl_page = data_addr_i[14:7];
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_q.ctrl <= flash_map_pkg::CTRL_RESET;
      state_q.busy <= 1'b0;
      state_q.boot_en <= flash_map_pkg::BOOT_EN_RESET;
      state_q.boot_init <= 1'b0;
      state_q.ljs <= flash_map_pkg::LJS_RESET;
      state_q.ulv <= flash_map_pkg::ULV_RESET;
      state_q.sec <= flash_map_pkg::SEC_RESET;
      state_q.rd_pend <= 1'b0;
      state_q.rd_is_sec <= 1'b0;
      state_q.code_data <= 8'h00;
      state_q.code_valid <= 1'b0;
      state_q.xwr <= 1'b0;
      state_q.xaddr <= 16'h0000;
      state_q.xdata <= 8'h00;
      state_q.xext <= 1'b0;
      state_q.cl_wr <= 1'b0;
      state_q.cl_page <= 8'h00;
      state_q.start_addr <= flash_map_pkg::BOOT_BASE;
    end else begin
      state_q <= state_d;
    end
  end

  // latch contents are not reset; the programming engine only reads bytes it was given
  always_ff @(posedge clock_i) begin
    if (latch_hit) begin
      col_latch[data_addr_i[6:0]] <= data_wdata_i;
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      latch_rd_q <= 8'h00;
    end else begin
      latch_rd_q <= col_latch[latch_rd_idx_i];
    end
  end

  assign code_data_o = state_q.code_data;
  assign code_valid_o = state_q.code_valid;
  assign xdata_wr_o = state_q.xwr;
  assign xdata_addr_o = state_q.xaddr;
  assign xdata_wdata_o = state_q.xdata;
  assign xdata_external_o = state_q.xext;
  assign flash_control_reg_o = {state_q.ctrl[7:1], state_q.busy};
  assign boot_flash_enable_o = state_q.boot_en;
  assign security_byte_o = state_q.sec;
  assign loader_jump_select_o = state_q.ljs;
  assign user_loader_vector_o = state_q.ulv;
  assign start_addr_o = state_q.start_addr;
  assign latch_rd_data_o = latch_rd_q;
  assign latch_page_o = state_q.cl_page;
  assign latch_wr_o = state_q.cl_wr;

endmodule : flash_space_mapping

// ---- flash_map_pkg.sv ----
// constants and types shared by the flash space mapping block
// Function
// - user array is 32 Kbytes, 256 pages of 128 bytes, holding application code
// - one extra row of 128 bytes sits beside the user pages
// - software reads and writes the upper four bits of the security byte
// - lower security nibble is read-only to software, set by parallel-mode hardware
// - a 128-byte column-latch page buffers programming data for all three spaces
// - by default the user array is read-only and reached only by code reads
// - with page-buffer select set, data writes 0000h-7FFFh go into column latches
// - address bits 6..0 pick the latch byte, bits 14..7 pick the page
// - page-buffer select overrides the external data mapping bit in that range
// - control value 00h maps user array for code reads 0000h-FFFFh
// - control value 02h maps extra row onto code reads FF80h-FFFFh
// - control value 04h maps security byte onto code read at 0000h
// - boot enable maps the 3 Kbyte boot array at F400h-FFFFh
// - loader jump select picks start at 0000h or F400h after reset
// - loader jump select 0 runs the boot loader; factory default
// - user loader vector gives user loader high address byte; FFh means none
// - control register reports whether flash is busy
package flash_map_pkg;
  localparam int PAGE_BYTES = 128;
  localparam int USER_PAGES = 256;
  localparam int BOOT_BYTES = 3072;
  localparam int CTRL_BUSY_BIT = 0;
  localparam int CTRL_MAP_LSB = 1;
  localparam int CTRL_PBUF_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [1:0] MAP_USER = 2'h0;
  localparam logic [1:0] MAP_ROW = 2'h1;
  localparam logic [1:0] MAP_SEC = 2'h2;
  localparam logic [15:0] COL_LATCH_TOP = 16'h7FFF;
  localparam logic [15:0] ROW_BASE = 16'hFF80;
  localparam logic [15:0] BOOT_BASE = 16'hF400;
  localparam logic [15:0] USER_START = 16'h0000;
  localparam logic [15:0] SEC_ADDR = 16'h0000;
  localparam logic [7:0] SEC_RESET = 8'hFF;
  localparam logic [7:0] SEC_SW_MASK = 8'hF0;
  localparam logic LJS_RESET = 1'b0;
  localparam logic [7:0] ULV_RESET = 8'hFF;
  localparam logic BOOT_EN_RESET = 1'b0;

  typedef enum logic [1:0] {
    SPACE_USER = 2'h0,
    SPACE_ROW = 2'h1,
    SPACE_SEC = 2'h2,
    SPACE_BOOT = 2'h3
  } space_type;
endpackage : flash_map_pkg

// ---- flash_array_if.sv ----
// carrier between the mapper and the flash array store
`timescale 1ns/1ps
interface flash_array_if;
  logic rd_en;
  flash_map_pkg::space_type rd_space;
  logic [15:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  flash_map_pkg::space_type wr_space;
  logic [15:0] wr_addr;
  logic [7:0] wr_data;
  modport mapper (output rd_en, rd_space, rd_addr, wr_en, wr_space, wr_addr, wr_data,
                  input rd_data);
  modport store (input rd_en, rd_space, rd_addr, wr_en, wr_space, wr_addr, wr_data,
                 output rd_data);
endinterface : flash_array_if

// ---- flash_arrays.sv ----
// storage of user array, extra row and boot array with one read and one write port
`timescale 1ns/1ps
module flash_arrays #(
  parameter int PAGE_BYTES = flash_map_pkg::PAGE_BYTES,
  parameter int USER_PAGES = flash_map_pkg::USER_PAGES,
  parameter int BOOT_BYTES = flash_map_pkg::BOOT_BYTES
) (
  input wire logic clock_i,
  flash_array_if.store arr
);
  localparam int USER_BYTES = USER_PAGES * PAGE_BYTES;

  // index slices below are fixed at 7, 15 and 12 bits, so other geometries cannot be served
  if (PAGE_BYTES != 128 || USER_BYTES != 32768 || BOOT_BYTES != 3072) begin : g_bad_geometry
    $error("flash_arrays: geometry must be 256x128 user, 128 row, 3072 boot");
  end

  logic [7:0] user_mem [USER_BYTES];
  logic [7:0] row_mem [PAGE_BYTES];
  logic [7:0] boot_mem [BOOT_BYTES];
  logic [7:0] rd_data_q;
  logic [15:0] boot_off;

  // boot array offset from its base; the base itself is the first byte
  assign boot_off = arr.rd_addr - flash_map_pkg::BOOT_BASE;
  assign arr.rd_data = rd_data_q;

  always_ff @(posedge clock_i) begin
    if (arr.rd_en) begin
      unique case (arr.rd_space)
        flash_map_pkg::SPACE_ROW: rd_data_q <= row_mem[arr.rd_addr[6:0]];
        flash_map_pkg::SPACE_BOOT: rd_data_q <= boot_mem[boot_off[11:0]];
        flash_map_pkg::SPACE_USER: rd_data_q <= user_mem[arr.rd_addr[14:0]];
        flash_map_pkg::SPACE_SEC: rd_data_q <= 8'h00;
      endcase
    end
  end

  // commit port for the programming engine; user array is never written by a plain read
  always_ff @(posedge clock_i) begin
    if (arr.wr_en) begin
      unique case (arr.wr_space)
        flash_map_pkg::SPACE_ROW: row_mem[arr.wr_addr[6:0]] <= arr.wr_data;
        flash_map_pkg::SPACE_BOOT: boot_mem[arr.wr_addr[11:0]] <= arr.wr_data;
        flash_map_pkg::SPACE_USER: user_mem[arr.wr_addr[14:0]] <= arr.wr_data;
        flash_map_pkg::SPACE_SEC: ;
      endcase
    end
  end
endmodule : flash_arrays

// ---- flash_space_mapping_assertions.sv ----
// concurrent checks on the flash space mapping ports
`timescale 1ns/1ps
module flash_space_mapping_checker (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic code_rd_i,
  input wire logic code_valid_o,
  input wire logic data_wr_i,
  input wire logic [15:0] data_addr_i,
  input wire logic external_data_map_i,
  input wire logic xdata_wr_o,
  input wire logic [15:0] xdata_addr_o,
  input wire logic xdata_external_o,
  input wire logic latch_wr_o,
  input wire logic [7:0] latch_page_o,
  input wire logic flash_control_wr_i,
  input wire logic [7:0] flash_control_wdata_i,
  input wire logic [7:0] flash_control_reg_o,
  input wire logic flash_busy_i,
  input wire logic sec_sw_wr_i,
  input wire logic [7:0] sec_sw_wdata_i,
  input wire logic sec_hw_wr_i,
  input wire logic [3:0] sec_hw_low_i,
  input wire logic [7:0] security_byte_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);
  logic fps_hit;
  assign fps_hit = flash_control_reg_o[3] && (data_addr_i <= 16'h7FFF);
  a_read_latency: assert property (code_rd_i |-> ##2 code_valid_o)
    else $error("read answer missing");
  a_valid_cause: assert property (code_valid_o |-> $past(code_rd_i, 2))
    else $error("answer without request");
  a_latch_route: assert property (data_wr_i && fps_hit |=> latch_wr_o && !xdata_wr_o
    && latch_page_o == $past(data_addr_i[14:7])) else $error("latch write misrouted");
  a_normal_route: assert property (data_wr_i && !fps_hit |=> xdata_wr_o && !latch_wr_o
    && xdata_addr_o == $past(data_addr_i) && xdata_external_o == $past(external_data_map_i))
    else $error("normal write misrouted");
  a_sec_sw_upper: assert property (sec_sw_wr_i && !sec_hw_wr_i |=> security_byte_o ==
    {$past(sec_sw_wdata_i[7:4]), $past(security_byte_o[3:0])}) else $error("sw security write");
  a_sec_hw_lower: assert property (sec_hw_wr_i && !sec_sw_wr_i |=> security_byte_o ==
    {$past(security_byte_o[7:4]), $past(sec_hw_low_i)}) else $error("hw security write");
  a_busy_status: assert property (flash_control_reg_o[0] == $past(flash_busy_i))
    else $error("busy bit stale");
  a_ctrl_write: assert property (flash_control_wr_i |=>
    flash_control_reg_o[7:1] == $past(flash_control_wdata_i[7:1])) else $error("control write");
endmodule : flash_space_mapping_checker

// ---- core_model.sv ----
// processor core model issuing code reads and data writes
`timescale 1ns/1ps
module core_model (
  input wire logic clock_i,
  input wire logic valid_i,
  input wire logic [7:0] rdata_i,
  output logic code_rd_o,
  output logic [15:0] code_addr_o,
  output logic data_wr_o,
  output logic [15:0] data_addr_o,
  output logic [7:0] data_wdata_o
);
  initial begin
    code_rd_o = 1'b0;
    code_addr_o = 16'hFFFF;
    data_wr_o = 1'b0;
    data_addr_o = 16'hFFFF;
    data_wdata_o = 8'hFF;
  end
  task automatic code_read(input logic [15:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_i);
    code_rd_o <= 1'b1;
    code_addr_o <= a;
    @(posedge clock_i);
    code_rd_o <= 1'b0;
    // released address flips to its complement and holds there, so a stale decode cannot look right
    code_addr_o <= ~a;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (valid_i !== 1'b1 && n < 4);
    d = (valid_i === 1'b1) ? rdata_i : 8'hXX;
  endtask : code_read
  task automatic data_write(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    data_wr_o <= 1'b1;
    data_addr_o <= a;
    data_wdata_o <= d;
    @(posedge clock_i);
    data_wr_o <= 1'b0;
    data_addr_o <= ~a;
    data_wdata_o <= ~d;
    #1;
  endtask : data_write
endmodule : core_model

// ---- flash_space_mapping_tb.sv ----
// self-checking bench for the flash space mapping block
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module flash_space_mapping_tb;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic external_data_map_i = 1'b0, flash_control_wr_i = 1'b0, flash_busy_i = 1'b0;
  logic aux_config_one_wr_i = 1'b0, boot_flash_enable_i = 1'b0, sec_sw_wr_i = 1'b0;
  logic sec_hw_wr_i = 1'b0, boot_cfg_wr_i = 1'b0, loader_jump_select_i = 1'b0;
  logic prog_wr_i = 1'b0;
  logic [7:0] flash_control_wdata_i = 8'h00, sec_sw_wdata_i = 8'h00, prog_data_i = 8'h00;
  logic [7:0] user_loader_vector_i = 8'h00, rd;
  logic [15:0] prog_addr_i = 16'h0000;
  logic [3:0] sec_hw_low_i = 4'h0;
  logic [6:0] latch_rd_idx_i = 7'h00;
  flash_map_pkg::space_type prog_space_i = flash_map_pkg::SPACE_USER;
  logic code_rd_i, data_wr_i, code_valid_o, xdata_wr_o, xdata_external_o, latch_wr_o;
  logic boot_flash_enable_o, loader_jump_select_o;
  logic [15:0] code_addr_i, data_addr_i, xdata_addr_o, start_addr_o;
  logic [7:0] data_wdata_i, code_data_o, xdata_wdata_o, flash_control_reg_o, security_byte_o;
  logic [7:0] user_loader_vector_o, latch_rd_data_o, latch_page_o;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;
  flash_space_mapping uut (.*);
  core_model core (.clock_i, .valid_i(code_valid_o), .rdata_i(code_data_o),
    .code_rd_o(code_rd_i), .code_addr_o(code_addr_i), .data_wr_o(data_wr_i),
    .data_addr_o(data_addr_i), .data_wdata_o(data_wdata_i));
  initial begin
    forever #5 clock_i = ~clock_i;
  end
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 4000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  task automatic ctrl_write(input logic [7:0] v);
    @(posedge clock_i);
    flash_control_wr_i <= 1'b1;
    flash_control_wdata_i <= v;
    @(posedge clock_i);
    flash_control_wr_i <= 1'b0;
    #1;
  endtask : ctrl_write
  task automatic prog(input flash_map_pkg::space_type s, input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_i);
    prog_wr_i <= 1'b1;
    prog_space_i <= s;
    prog_addr_i <= a;
    prog_data_i <= d;
    @(posedge clock_i);
    prog_wr_i <= 1'b0;
  endtask : prog
  task automatic read_chk(input logic [15:0] a, input logic [7:0] e);
    core.code_read(a, rd);
    `CHK("code byte", e, rd)
  endtask : read_chk
  task automatic reset_chk;
    @(posedge clock_i);
    sys_rst_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    #1;
    `CHK("boot enable", 1'b1, boot_flash_enable_o)
    `CHK("start", 16'hF400, start_addr_o)
    `CHK("jump select", 1'b0, loader_jump_select_o)
    `CHK("vector", 8'hFF, user_loader_vector_o)
    `CHK("control", 8'h00, flash_control_reg_o)
  endtask : reset_chk
  task automatic t_sec;
    @(posedge clock_i);
    sec_sw_wr_i <= 1'b1;
    sec_sw_wdata_i <= 8'h3C;
    @(posedge clock_i);
    sec_sw_wr_i <= 1'b0;
    sec_hw_wr_i <= 1'b1;
    sec_hw_low_i <= 4'h6;
    #1;
    `CHK("security sw", 8'h3F, security_byte_o)
    @(posedge clock_i);
    sec_hw_wr_i <= 1'b0;
    #1;
    `CHK("security hw", 8'h36, security_byte_o)
  endtask : t_sec
  task automatic t_maps;
    prog(flash_map_pkg::SPACE_BOOT, 16'h0010, 8'hB7);
    prog(flash_map_pkg::SPACE_ROW, 16'h0000, 8'h5A);
    prog(flash_map_pkg::SPACE_USER, 16'h0000, 8'h11);
    prog(flash_map_pkg::SPACE_USER, 16'h7F80, 8'h3C);
    read_chk(16'hF410, 8'hB7);
    ctrl_write(8'h02);
    read_chk(16'hFF80, 8'h5A);
    ctrl_write(8'h04);
    read_chk(16'h0000, 8'h36);
    ctrl_write(8'h00);
    read_chk(16'h0000, 8'h11);
    @(posedge clock_i);
    aux_config_one_wr_i <= 1'b1;
    @(posedge clock_i);
    aux_config_one_wr_i <= 1'b0;
    #1;
    `CHK("boot off", 1'b0, boot_flash_enable_o)
    read_chk(16'hFF80, 8'h3C);
  endtask : t_maps
  task automatic t_latch;
    ctrl_write(8'h08);
    @(posedge clock_i);
    external_data_map_i <= 1'b1;
    latch_rd_idx_i <= 7'h7F;
    core.data_write(16'h7FFF, 8'hC3);
    `CHK("latch write", 1'b1, latch_wr_o)
    `CHK("latch page", 8'hFF, latch_page_o)
    `CHK("forwarded", 1'b0, xdata_wr_o)
    @(posedge clock_i);
    #1;
    `CHK("latch byte", 8'hC3, latch_rd_data_o)
    core.data_write(16'h8000, 8'h44);
    `CHK("high forward", 16'h8000, xdata_addr_o)
    `CHK("external copy", 1'b1, xdata_external_o)
    ctrl_write(8'h00);
    core.data_write(16'h007F, 8'h99);
    `CHK("normal data", 8'h99, xdata_wdata_o)
    @(posedge clock_i);
    #1;
    `CHK("latch kept", 8'hC3, latch_rd_data_o)
  endtask : t_latch
  task automatic t_busy_cfg;
    @(posedge clock_i);
    flash_busy_i <= 1'b1;
    ctrl_write(8'h0E);
    `CHK("busy set", 8'h0F, flash_control_reg_o)
    @(posedge clock_i);
    flash_busy_i <= 1'b0;
    ctrl_write(8'h01);
    `CHK("busy clear", 8'h00, flash_control_reg_o)
    @(posedge clock_i);
    boot_cfg_wr_i <= 1'b1;
    loader_jump_select_i <= 1'b1;
    user_loader_vector_i <= 8'h12;
    @(posedge clock_i);
    boot_cfg_wr_i <= 1'b0;
    #1;
    `CHK("jump select", 1'b1, loader_jump_select_o)
    `CHK("vector", 8'h12, user_loader_vector_o)
    @(posedge clock_i);
    #1;
    `CHK("start user", 16'h0000, start_addr_o)
  endtask : t_busy_cfg
  initial begin
    reset_chk();
    t_sec();
    t_maps();
    t_latch();
    t_busy_cfg();
    reset_chk();
    tally_and_finish();
  end
endmodule : flash_space_mapping_tb
bind flash_space_mapping flash_space_mapping_checker chk (.*);
